// ### hdl/qiedd_top.sv
// quad input edge/event/diagnostic unit: filters, edge events,
// process event capture, diagnostic record and fault indicator
// assumes the controller reads records and acks process events
`timescale 1ns/10ps
`include "qiedd_defines.svh"

module qiedd_top (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [3:0] i_field_input_n,
    input wire qiedd_pkg::qiedd_rec_req_t i_rec_req,
    input wire logic i_proc_ack,
    input wire logic i_host_canopen,
    output logic [7:0] o_rec_rdata,
    output logic o_rec_ack,
    output qiedd_pkg::qiedd_pe_t o_proc_event,
    output logic o_proc_valid,
    output logic o_diag_incoming,
    output logic o_diag_going,
    output logic o_module_fault_indicator
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ****************************************************************
    // microsecond tick and ticker
    // ****************************************************************
    logic [6:0] div_r;
    logic us_tick_r;
    logic [31:0] ticker_r;
    logic div_end;

    assign div_end = div_r == 7'(`QIEDD_US_CYCLES - 1);

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 7'h00;
            us_tick_r <= 1'b0;
        end else begin
            div_r <= div_end ? 7'h00 : div_r + 7'h01;
            us_tick_r <= div_end;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ticker_r <= 32'h0000_0000;
        end else if (us_tick_r) begin
            ticker_r <= ticker_r + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // parameter records
    // ****************************************************************
    logic [7:0] diag_enable_r;
    logic [7:0] input_delay_code_r [0:3];
    logic [3:0] rising_edge_enable_r;
    logic [3:0] falling_edge_enable_r;
    logic diag_on;
    logic wr_set00;
    logic wr_set01;
    logic wr_set80;

    assign wr_set00 = i_rec_req.wr && i_rec_req.set == `QIEDD_SET_00;
    assign wr_set01 = i_rec_req.wr && i_rec_req.set == `QIEDD_SET_01;
    assign wr_set80 = i_rec_req.wr && i_rec_req.set == `QIEDD_SET_80;
    assign diag_on = diag_enable_r == `QIEDD_DIAG_ON;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            diag_enable_r <= `QIEDD_DIAG_OFF;
        end else if (wr_set00 && i_rec_req.idx == 5'h00) begin
            diag_enable_r <= i_rec_req.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rising_edge_enable_r <= 4'h0;
            falling_edge_enable_r <= 4'h0;
        end else if (wr_set80) begin
            if (i_rec_req.idx == `QIEDD_IDX_RISE) begin
                rising_edge_enable_r <= i_rec_req.wdata[3:0];
            end
            if (i_rec_req.idx == `QIEDD_IDX_FALL) begin
                falling_edge_enable_r <= i_rec_req.wdata[3:0];
            end
        end
    end

    // ****************************************************************
    // per channel sync and filter
    // ****************************************************************
    logic [3:0] filt;
    logic [3:0] filt_prev_r;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ch
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic stable_r;

            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    stable_r <= 1'b0;
                    input_delay_code_r[ch] <= `QIEDD_DLY_RESET;
                end else begin
                    s1_r <= i_field_input_n[ch];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    stable_r <= (s2_r == s3_r) ? s3_r : stable_r;
                    if (wr_set01 && i_rec_req.idx == 5'(ch)) begin
                        input_delay_code_r[ch] <= i_rec_req.wdata;
                    end
                end
            end

            qiedd_filter u_filter (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(rst_n),
                .i_us_tick(us_tick_r),
                .i_raw(stable_r),
                .i_delay_code(input_delay_code_r[ch]),
                .o_level(filt[ch])
            );
        end
    endgenerate

    // ****************************************************************
    // edge detection and process events
    // ****************************************************************
    logic [3:0] edges;
    logic ev_now;
    logic accept;
    logic loss;
    logic dg_active;
    qiedd_pkg::qiedd_pe_t pe_nxt;

    assign edges = (filt & ~filt_prev_r & rising_edge_enable_r) |
                   (~filt & filt_prev_r & falling_edge_enable_r);
    assign ev_now = |edges && !dg_active;
    assign accept = ev_now && (!o_proc_valid || i_proc_ack);
    assign loss = ev_now && o_proc_valid && !i_proc_ack;

    assign pe_nxt = '{canopen_emcy: i_host_canopen,
                      edge_mask: {4'h0, edges},
                      snapshot: {4'h0, filt},
                      time_low: ticker_r[15:0]};

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filt_prev_r <= 4'h0;
            o_proc_valid <= 1'b0;
            o_proc_event <= '0;
        end else begin
            filt_prev_r <= filt;
            o_proc_valid <= accept || (o_proc_valid && !i_proc_ack);
            if (accept) begin
                o_proc_event <= pe_nxt;
            end
        end
    end

    // ****************************************************************
    // diagnostic cause and window
    // ****************************************************************
    logic [3:0] lost_edge_acc_r;
    logic lost_acc_r;
    logic ovf_acc_r;
    logic cause;
    logic go_in;
    logic go_out;
    qiedd_pkg::qiedd_dg_state_t dg_state_r;
    qiedd_pkg::qiedd_dg_state_t dg_state_nxt;

    assign cause = lost_acc_r;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lost_edge_acc_r <= 4'h0;
            lost_acc_r <= 1'b0;
            ovf_acc_r <= 1'b0;
        end else if (loss) begin
            lost_edge_acc_r <= lost_edge_acc_r | edges;
            lost_acc_r <= 1'b1;
            ovf_acc_r <= ovf_acc_r | lost_acc_r;
        end else if (!o_proc_valid) begin
            lost_edge_acc_r <= 4'h0;
            lost_acc_r <= 1'b0;
            ovf_acc_r <= 1'b0;
        end
    end

    assign dg_active = dg_state_r == qiedd_pkg::QIEDD_DG_ACTIVE;
    assign go_in = !dg_active && diag_on && cause;
    assign go_out = dg_active && !cause;

    always_comb begin
        case (dg_state_r)
            qiedd_pkg::QIEDD_DG_IDLE: begin
                dg_state_nxt = go_in ? qiedd_pkg::QIEDD_DG_ACTIVE : qiedd_pkg::QIEDD_DG_IDLE;
            end
            qiedd_pkg::QIEDD_DG_ACTIVE: begin
                dg_state_nxt = go_out ? qiedd_pkg::QIEDD_DG_IDLE : qiedd_pkg::QIEDD_DG_ACTIVE;
            end
            default: begin
                dg_state_nxt = qiedd_pkg::QIEDD_DG_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // diagnostic record capture
    // ****************************************************************
    logic [7:0] diag_summary_r;
    logic [7:0] diag_internal_flags_r;
    logic [7:0] lost_edge_flags_r;
    logic [31:0] diag_ts_r;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dg_state_r <= qiedd_pkg::QIEDD_DG_IDLE;
            o_diag_incoming <= 1'b0;
            o_diag_going <= 1'b0;
            o_module_fault_indicator <= 1'b0;
        end else begin
            dg_state_r <= dg_state_nxt;
            o_diag_incoming <= go_in;
            o_diag_going <= go_out;
            o_module_fault_indicator <= dg_state_nxt == qiedd_pkg::QIEDD_DG_ACTIVE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            diag_summary_r <= 8'h00;
            diag_internal_flags_r <= 8'h00;
            lost_edge_flags_r <= 8'h00;
            diag_ts_r <= 32'h0000_0000;
        end else if (go_in) begin
            diag_summary_r <= 8'h00;
            diag_summary_r[`QIEDD_BIT_CH_ERR] <= |lost_edge_acc_r;
            diag_internal_flags_r <= 8'h00;
            diag_internal_flags_r[`QIEDD_BIT_PE_LOST] <= lost_acc_r;
            diag_internal_flags_r[`QIEDD_BIT_OVERFLOW] <= ovf_acc_r;
            lost_edge_flags_r <= {4'h0, lost_edge_acc_r};
            diag_ts_r <= ticker_r;
        end
    end

    // ****************************************************************
    // record read port
    // ****************************************************************
    logic [159:0] diag_vec;
    logic [7:0] diag_byte;
    logic rd_full;
    logic rd_short;
    logic [7:0] rdata_nxt;

    assign diag_vec = {diag_ts_r, 64'h0000_0000_0000_0000, lost_edge_flags_r,
                       `QIEDD_CHANNEL_COUNT, `QIEDD_DIAG_BITS_PER_CH, `QIEDD_CHANNEL_KIND,
                       diag_internal_flags_r, 8'h00, `QIEDD_MODULE_CLASS_INFO, diag_summary_r};
    assign diag_byte = diag_vec[{i_rec_req.idx, 3'b000} +: 8];
    assign rd_full = i_rec_req.set == `QIEDD_SET_01 && i_rec_req.idx < `QIEDD_DIAG_LEN;
    assign rd_short = i_rec_req.set == `QIEDD_SET_00 && i_rec_req.idx < `QIEDD_SHORT_LEN;
    assign rdata_nxt = (rd_full || rd_short) ? diag_byte : 8'h00;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_rec_rdata <= 8'h00;
            o_rec_ack <= 1'b0;
        end else begin
            o_rec_ack <= i_rec_req.rd || i_rec_req.wr;
            o_rec_rdata <= i_rec_req.rd ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_edge_free;
        |edges && !dg_active && !o_proc_valid;
    endsequence

    sequence s_event_out;
        o_proc_valid && o_proc_event.edge_mask[3:0] == $past(edges);
    endsequence

    property p_gate;
        o_diag_incoming |-> $past(diag_on) && $past(cause);
    endproperty
    a_gate: assert property (p_gate) else $error("incoming while disabled");

    property p_event;
        s_edge_free |=> s_event_out;
    endproperty
    a_event: assert property (p_event) else $error("enabled edge gave no event");

    property p_mask;
        o_proc_event.edge_mask[7:4] == 4'h0 && o_proc_event.snapshot[7:4] == 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("reserved event bits set");

    property p_snap;
        $rose(o_proc_valid) |-> o_proc_event.snapshot[3:0] == $past(filt);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot mismatch");

    property p_time;
        $rose(o_proc_valid) |-> o_proc_event.time_low == $past(ticker_r[15:0]);
    endproperty
    a_time: assert property (p_time) else $error("event time mismatch");

    property p_ticker;
        us_tick_r |=> ticker_r == $past(ticker_r) + 32'h0000_0001 ##1 !us_tick_r [*8];
    endproperty
    a_ticker: assert property (p_ticker) else $error("ticker step wrong");

    property p_going;
        dg_active && !cause |=> o_diag_going && !o_module_fault_indicator;
    endproperty
    a_going: assert property (p_going) else $error("going event missing");

    property p_discard;
        dg_active && |edges && o_proc_valid |=> $stable(o_proc_event);
    endproperty
    a_discard: assert property (p_discard) else $error("edge kept in window");

    property p_led;
        o_diag_incoming |-> o_module_fault_indicator throughout (!o_diag_going [*1]);
    endproperty
    a_led: assert property (p_led) else $error("fault indicator not lit");

    property p_lost;
        loss |=> lost_acc_r && (lost_edge_acc_r & $past(edges)) == $past(edges);
    endproperty
    a_lost: assert property (p_lost) else $error("lost edge not recorded");

    property p_stamp;
        o_diag_incoming |-> diag_ts_r == $past(ticker_r);
    endproperty
    a_stamp: assert property (p_stamp) else $error("diagnostic time mismatch");

endmodule // qiedd_top

// ### shared/qiedd_defines.svh
// constants of the quad input edge/event/diagnostic block
// assumes a 100 MHz system clock and byte-wide record access
`ifndef QIEDD_DEFINES_SVH
`define QIEDD_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define QIEDD_CLK_PERIOD_NS 10
`define QIEDD_US_NS 1000
`define QIEDD_US_CYCLES (`QIEDD_US_NS / `QIEDD_CLK_PERIOD_NS)

// ****************************************************************
// input delay codes and their delay in microseconds
// ****************************************************************
`define QIEDD_DLY_CODE_1US 8'h00
`define QIEDD_DLY_CODE_3US 8'h02
`define QIEDD_DLY_CODE_10US 8'h04
`define QIEDD_DLY_CODE_86US 8'h07
`define QIEDD_DLY_CODE_342US 8'h09
`define QIEDD_DLY_CODE_2731US 8'h0c
`define QIEDD_DLY_1US 12'h001
`define QIEDD_DLY_3US 12'h003
`define QIEDD_DLY_10US 12'h00a
`define QIEDD_DLY_86US 12'h056
`define QIEDD_DLY_342US 12'h156
`define QIEDD_DLY_2731US 12'haab

// ****************************************************************
// record sets and byte indices
// ****************************************************************
`define QIEDD_SET_00 8'h00
`define QIEDD_SET_01 8'h01
`define QIEDD_SET_80 8'h80
`define QIEDD_SHORT_LEN 5'h04
`define QIEDD_DIAG_LEN 5'h14
`define QIEDD_IDX_RISE 5'h00
`define QIEDD_IDX_FALL 5'h01

// ****************************************************************
// reset and constant field values
// ****************************************************************
`define QIEDD_DIAG_OFF 8'h00
`define QIEDD_DIAG_ON 8'h40
`define QIEDD_DLY_RESET 8'h02
`define QIEDD_MODULE_CLASS_INFO 8'h1f
`define QIEDD_CHANNEL_KIND 8'h70
`define QIEDD_DIAG_BITS_PER_CH 8'h00
`define QIEDD_CHANNEL_COUNT 8'h04
`define QIEDD_BIT_MOD_FAIL 0
`define QIEDD_BIT_EXT_ERR 2
`define QIEDD_BIT_CH_ERR 3
`define QIEDD_BIT_OVERFLOW 3
`define QIEDD_BIT_PE_LOST 6

`endif

// ### shared/qiedd_pkg.sv
// types of the quad input edge/event/diagnostic block
// holds its own state encodings; takes no numbers from the defines header
package qiedd_pkg;

    // record access request from the controller
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] set;
        logic [4:0] idx;
        logic [7:0] wdata;
    } qiedd_rec_req_t;

    // process event data handed to the controller
    typedef struct packed {
        logic        canopen_emcy;
        logic [7:0]  edge_mask;
        logic [7:0]  snapshot;
        logic [15:0] time_low;
    } qiedd_pe_t;

    typedef enum logic [1:0] {
        QIEDD_DG_IDLE   = 2'b01,
        QIEDD_DG_ACTIVE = 2'b10
    } qiedd_dg_state_t;

endpackage

// ### hdl/qiedd_filter.sv
// one channel input filter, counted in microsecond ticks
// assumes a synchronised raw level and a one-cycle microsecond tick
`timescale 1ns/10ps
`include "qiedd_defines.svh"

module qiedd_filter (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_us_tick,
    input wire logic i_raw,
    input wire logic [7:0] i_delay_code,
    output logic o_level
);

    logic [11:0] dly;
    logic [11:0] cnt_r;
    logic level_r;
    logic differ;
    logic done;

    // ****************************************************************
    // delay lookup
    // ****************************************************************
    // code to delay
    assign dly = (i_delay_code == `QIEDD_DLY_CODE_1US) ? `QIEDD_DLY_1US :
                 (i_delay_code == `QIEDD_DLY_CODE_10US) ? `QIEDD_DLY_10US :
                 (i_delay_code == `QIEDD_DLY_CODE_86US) ? `QIEDD_DLY_86US :
                 (i_delay_code == `QIEDD_DLY_CODE_342US) ? `QIEDD_DLY_342US :
                 (i_delay_code == `QIEDD_DLY_CODE_2731US) ? `QIEDD_DLY_2731US :
                 `QIEDD_DLY_3US;
    assign differ = i_raw != level_r;
    // one extra tick so the hold is never shorter than the delay
    assign done = i_us_tick && (cnt_r >= dly);

    // ****************************************************************
    // hold counter
    // ****************************************************************
    // level after hold
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 12'h000;
            level_r <= 1'b0;
        end else if (!differ || done) begin
            cnt_r <= 12'h000;
            level_r <= differ ? i_raw : level_r;
        end else if (i_us_tick) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    assign o_level = level_r;

    property p_filter_tick;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $changed(level_r) |-> $past(i_us_tick) && $past(differ);
    endproperty
    a_filter_tick: assert property (p_filter_tick) else $error("filter moved off tick");

endmodule // qiedd_filter

// ### dv/qiedd_ctrl_model.sv
// controller model: takes pending process events after a short delay
// assumes the bench drives the hold input to keep an event pending
`timescale 1ns/10ps

module qiedd_ctrl_model (
    input wire logic i_clk_sys,
    input wire logic i_hold,
    input wire logic i_valid,
    output logic o_ack
);
    logic [3:0] wait_r;

    initial begin
        o_ack = 1'b0;
        wait_r = 4'h0;
    end

    // ****
    // acknowledge only while an event stands
    // ****
    always @(posedge i_clk_sys) begin
        o_ack <= 1'b0;
        if (i_valid && !o_ack && !i_hold) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r == 4'h3) begin
                o_ack <= 1'b1;
                wait_r <= 4'h0;
            end
        end else begin
            wait_r <= 4'h0;
        end
    end
endmodule // qiedd_ctrl_model

// ### dv/qiedd_tb_top.sv
// bench of the quad input edge/event/diagnostic unit
// assumes the controller model acknowledges events unless held
`timescale 1ns/10ps

module qiedd_tb_top;
    logic clk;
    logic resetn;
    logic [3:0] fin;
    qiedd_pkg::qiedd_rec_req_t req;
    logic ack;
    logic hold;
    logic canopen;
    logic [7:0] rdata;
    logic [7:0] rd_byte;
    logic rack;
    qiedd_pkg::qiedd_pe_t pe;
    logic valid;
    logic incoming;
    logic going;
    logic led;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_in = 0;
    int n_go = 0;

    qiedd_top uut (.i_clk_sys(clk), .i_resetn(resetn), .i_field_input_n(fin),
        .i_rec_req(req), .i_proc_ack(ack), .i_host_canopen(canopen),
        .o_rec_rdata(rdata), .o_rec_ack(rack), .o_proc_event(pe),
        .o_proc_valid(valid), .o_diag_incoming(incoming), .o_diag_going(going),
        .o_module_fault_indicator(led));

    qiedd_ctrl_model ctrl (.i_clk_sys(clk), .i_hold(hold), .i_valid(valid),
        .o_ack(ack));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****
    // shared tasks
    // ****
    task automatic complete_run();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (incoming === 1'b1) n_in <= n_in + 1;
        if (going === 1'b1) n_go <= n_go + 1;
        if (cyc == 40000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            mismatches++;
        end
    endtask

    task automatic rec(input logic wr, input logic [7:0] set, input logic [4:0] idx,
        input logic [7:0] wd);
        @(posedge clk);
        req <= {wr, !wr, set, idx, wd};
        @(posedge clk);
        req <= '0;
        #1;
        check(rack, 1'b1);
        rd_byte = rdata;
    endtask

    task automatic rdchk(input logic [7:0] set, input logic [4:0] idx, input logic [7:0] e);
        rec(1'b0, set, idx, 8'h00);
        check(rd_byte, e);
    endtask

    task automatic pin(input int b, input logic v);
        @(posedge clk);
        fin[b] <= v;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_valid(output int at);
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 800) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(valid, 1'b1);
        at = cyc;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_consts();
        logic [7:0] tbl [20];
        tbl = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h70, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        rec(1'b1, 8'h42, 5'h00, 8'h55);
        for (int i = 0; i < 20; i++) rdchk(8'h01, i[4:0], tbl[i]);
        for (int i = 0; i < 4; i++) rdchk(8'h00, i[4:0], tbl[i]);
        rdchk(8'h00, 5'h04, 8'h00);
        rdchk(8'h42, 5'h00, 8'h00);
    endtask

    task automatic t_rise();
        int s;
        int a1;
        int a2;
        logic [15:0] t1;
        for (int i = 0; i < 4; i++) rec(1'b1, 8'h01, i[4:0], 8'h00);
        rec(1'b1, 8'h80, 5'h00, 8'hf4);
        s = cyc;
        pin(2, 1'b1);
        wait_valid(a1);
        check(a1 - s >= 100, 1'b1);
        check(pe.edge_mask, 8'h04);
        check(pe.snapshot, 8'h04);
        check(pe.canopen_emcy, 1'b1);
        t1 = pe.time_low;
        idle(300);
        rec(1'b1, 8'h80, 5'h00, 8'h0f);
        pin(3, 1'b1);
        wait_valid(a2);
        check(pe.edge_mask, 8'h08);
        check(pe.snapshot, 8'h0c);
        s = (a2 - a1) / 100 - int'(pe.time_low - t1);
        check(s >= -1 && s <= 1, 1'b1);
        idle(20);
    endtask

    task automatic t_fall();
        int a;
        pin(3, 1'b0);
        idle(400);
        check(valid, 1'b0);
        rec(1'b1, 8'h80, 5'h00, 8'h00);
        pin(1, 1'b1);
        idle(400);
        check(valid, 1'b0);
        rec(1'b1, 8'h80, 5'h01, 8'h02);
        @(posedge clk);
        canopen <= 1'b0;
        pin(1, 1'b0);
        wait_valid(a);
        check(pe.edge_mask, 8'h02);
        check(pe.snapshot, 8'h04);
        check(pe.canopen_emcy, 1'b0);
        idle(20);
    endtask

    task automatic lose_ch0();
        int a;
        hold <= 1'b1;
        pin(0, 1'b1);
        wait_valid(a);
        pin(0, 1'b0);
        idle(400);
    endtask

    task automatic t_diag();
        rec(1'b1, 8'h80, 5'h00, 8'h09);
        rec(1'b1, 8'h80, 5'h01, 8'h01);
        lose_ch0();
        pin(0, 1'b1);
        idle(400);
        check(n_in, 0);
        check(led, 1'b0);
        rec(1'b1, 8'h00, 5'h00, 8'h40);
        idle(5);
        check(n_in, 1);
        check(led, 1'b1);
        rdchk(8'h01, 5'h00, 8'h08);
        rdchk(8'h01, 5'h03, 8'h48);
        rdchk(8'h01, 5'h07, 8'h01);
        rdchk(8'h00, 5'h03, 8'h48);
        pin(3, 1'b1);
        idle(400);
        hold <= 1'b0;
        idle(100);
        check(n_go, 1);
        check(led, 1'b0);
        check(valid, 1'b0);
        check(pe.edge_mask, 8'h01);
    endtask

    initial begin
        resetn = 1'b0;
        fin = 4'h0;
        req = '0;
        hold = 1'b0;
        canopen = 1'b1;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        idle(5);
        t_consts();
        t_rise();
        t_fall();
        t_diag();
        complete_run();
    end
endmodule // qiedd_tb_top
